// ### src/hbi_pkg.sv
// hbi_pkg: constants and carrier types for the host bus pin interface.
// assumes one 100 MHz core clock; host pins are already synchronous to it.
package hbi_pkg;

    // ==========================================================
    // widths and sizes
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;     // host address bits 9..2
    localparam int unsigned FIFO_DEPTH = 16;

    // ==========================================================
    // word-index map of the data ports inside the address space
    localparam logic [7:0] RX_DATA_IDX = 8'h00;
    localparam logic [7:0] TX_DATA_IDX = 8'h01;

    // ==========================================================
    // reset and default values
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic [31:0] EMPTY_READ_VAL = 32'h0000_0000;
    localparam logic [7:0] ADDR_RST = 8'h00;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic chip_select_n;
        logic read_strobe_n;
        logic write_strobe_n;
        logic [7:0] addr;
        logic direct_fifo;
        logic big_endian;
    } hbi_req_type;

    typedef enum {
        BUS_IDLE,
        BUS_READ,
        BUS_WRITE
    } hbi_state_type;

endpackage : hbi_pkg

// ### src/hbi_fifo.sv
// hbi_fifo: flip-flop FIFO with valid/ready on both sides.
// assumes a single clock; full and empty are exact, no bypass path.
module hbi_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wptr_ff;
    logic [PW-1:0] rptr_ff;
    logic [PW:0] count_ff;
    wire logic push;
    wire logic pop;

    assign wr_ready_out = (count_ff != (PW + 1)'(DEPTH));
    assign rd_valid_out = (count_ff != '0);
    assign push = wr_valid_in && wr_ready_out;
    assign pop = rd_valid_out && rd_ready_in;
    assign rd_data_out = mem_ff[rptr_ff];

    always_ff @(posedge core_clk_in) begin
        if (push) begin
            mem_ff[wptr_ff] <= wr_data_in;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wptr_ff <= wptr_ff + 1'b1;
            end
            if (pop) begin
                rptr_ff <= rptr_ff + 1'b1;
            end
            count_ff <= count_ff + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        end
    end

endmodule : hbi_fifo

// ### src/hbi_host_port.sv
// hbi_host_port: device side of the 32-bit strobe host bus.
// assumes host pins are synchronous to core_clk_in and that the internal
// register file answers reg_rdata_in in the same cycle as reg_rd_out.
module hbi_host_port (
    input wire logic core_clk_in,
    input wire logic rst_in,
    // host pins
    input wire logic [31:0] host_data_in,
    output logic [31:0] host_data_out,
    output logic host_data_oe_out,
    input wire logic [7:0] host_addr_in,
    input wire logic read_strobe_n_in,
    input wire logic write_strobe_n_in,
    input wire logic chip_select_n_in,
    input wire logic direct_fifo_sel_in,
    input wire logic big_endian_sel_in,
    // internal register file
    output logic [7:0] reg_addr_out,
    output logic [31:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    input wire logic [31:0] reg_rdata_in,
    // transmit data stream out of the device core side
    output logic [31:0] tx_data_out,
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    // receive data stream into the host
    input wire logic [31:0] rx_data_in,
    input wire logic rx_valid_in,
    output logic rx_ready_out
);
    // =========================================================
    // pin bundle
    hbi_pkg::hbi_req_type req;
    assign req.chip_select_n = chip_select_n_in;
    assign req.read_strobe_n = read_strobe_n_in;
    assign req.write_strobe_n = write_strobe_n_in;
    assign req.addr = host_addr_in;
    assign req.direct_fifo = direct_fifo_sel_in;
    assign req.big_endian = big_endian_sel_in;

    function automatic logic [31:0] swap_bytes(input logic [31:0] w);
        swap_bytes = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : swap_bytes

    // =========================================================
    // access decode
    hbi_pkg::hbi_state_type state_ff;
    hbi_pkg::hbi_state_type nxt_state;
    logic [31:0] rdata_ff;

    wire logic sel = !req.chip_select_n;
    wire logic rd_act = sel && !req.read_strobe_n;
    wire logic wr_act = sel && !req.write_strobe_n;
    // one action per strobe: only the idle-to-active step acts
    wire logic rd_start = (state_ff == hbi_pkg::BUS_IDLE) && rd_act;
    wire logic wr_start = (state_ff == hbi_pkg::BUS_IDLE) && wr_act
                          && !rd_act;
    // direct mode overrides the address decode
    wire logic to_rx = req.direct_fifo
                       || (req.addr == hbi_pkg::RX_DATA_IDX);
    wire logic to_tx = req.direct_fifo
                       || (req.addr == hbi_pkg::TX_DATA_IDX);
    // byte order is taken from the pin during this very access
    wire logic [31:0] wr_word = req.big_endian
                                ? swap_bytes(host_data_in)
                                : host_data_in;

    // =========================================================
    // data FIFOs
    wire logic tx_push = wr_start && to_tx;
    wire logic rx_pop = rd_start && to_rx;
    wire logic tx_room;
    wire logic [31:0] rx_head;
    wire logic rx_has;

    // a write to a full transmit FIFO is lost; the host must poll levels
    hbi_fifo #(
        .WIDTH(hbi_pkg::DATA_W),
        .DEPTH(hbi_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .wr_data_in(wr_word),
        .wr_valid_in(tx_push),
        .wr_ready_out(tx_room),
        .rd_data_out(tx_data_out),
        .rd_valid_out(tx_valid_out),
        .rd_ready_in(tx_ready_in)
    );

    hbi_fifo #(
        .WIDTH(hbi_pkg::DATA_W),
        .DEPTH(hbi_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .wr_data_in(rx_data_in),
        .wr_valid_in(rx_valid_in),
        .wr_ready_out(rx_ready_out),
        .rd_data_out(rx_head),
        .rd_valid_out(rx_has),
        .rd_ready_in(rx_pop)
    );

    // =========================================================
    // register side
    assign reg_addr_out = req.addr;
    assign reg_wdata_out = wr_word;
    assign reg_wr_out = wr_start && !to_tx;
    assign reg_rd_out = rd_start && !to_rx;

    wire logic [31:0] rd_src = to_rx
                               ? (rx_has ? rx_head : hbi_pkg::EMPTY_READ_VAL)
                               : reg_rdata_in;
    wire logic [31:0] rd_word = req.big_endian
                                ? swap_bytes(rd_src)
                                : rd_src;

    // =========================================================
    // state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            hbi_pkg::BUS_IDLE: begin
                if (rd_act) begin
                    nxt_state = hbi_pkg::BUS_READ;
                end else if (wr_act) begin
                    nxt_state = hbi_pkg::BUS_WRITE;
                end
            end
            hbi_pkg::BUS_READ: begin
                if (!rd_act) begin
                    nxt_state = hbi_pkg::BUS_IDLE;
                end
            end
            hbi_pkg::BUS_WRITE: begin
                if (!wr_act) begin
                    nxt_state = hbi_pkg::BUS_IDLE;
                end
            end
            default: begin
                nxt_state = hbi_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= hbi_pkg::BUS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // read word is captured once at the strobe's start and held
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_ff <= hbi_pkg::DATA_RST;
        end else if (rd_start) begin
            rdata_ff <= rd_word;
        end
    end

    assign host_data_out = rdata_ff;
    // drive only while the read strobe and chip select are both low
    assign host_data_oe_out = (state_ff == hbi_pkg::BUS_READ)
                              && rd_act;

    // =========================================================
    // checks
    sequence s_read_begins;
        rd_start && to_rx && rx_has;
    endsequence

    sequence s_word_driven;
        host_data_oe_out [*1];
    endsequence

    a_oe_needs_select: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        host_data_oe_out |-> (!chip_select_n_in && !read_strobe_n_in))
        else $error("data bus driven outside a selected read");

    a_idle_when_deselect: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        chip_select_n_in |-> !(reg_wr_out || reg_rd_out || tx_push || rx_pop))
        else $error("access taken while chip select high");

    a_direct_write_push: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        (wr_start && direct_fifo_sel_in) |-> (tx_push && !reg_wr_out))
        else $error("direct write did not go to transmit FIFO");

    a_direct_read_pop: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        (rd_start && direct_fifo_sel_in) |-> (rx_pop && !reg_rd_out))
        else $error("direct read did not go to receive FIFO");

    a_addr_ignored_direct: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        direct_fifo_sel_in |-> !(reg_rd_out || reg_wr_out))
        else $error("register reached in direct FIFO mode");

    a_reg_write_decode: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        reg_wr_out |-> (host_addr_in != hbi_pkg::TX_DATA_IDX
                        && reg_addr_out == host_addr_in))
        else $error("register write decoded wrongly");

    a_big_endian_write: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        (reg_wr_out && big_endian_sel_in)
        |-> reg_wdata_out == {host_data_in[7:0], host_data_in[15:8],
                              host_data_in[23:16], host_data_in[31:24]})
        else $error("big endian write not byte reversed");

    a_little_endian_read: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        (reg_rd_out && !big_endian_sel_in) ##1 s_word_driven
        |-> host_data_out == $past(reg_rdata_in))
        else $error("little endian read word changed");

    a_fifo_read_data: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        (s_read_begins and big_endian_sel_in)
        |=> host_data_out == swap_bytes($past(rx_head)))
        else $error("big endian FIFO read not byte reversed");

    a_one_write_strobe: assert property (
        @(posedge core_clk_in) disable iff (rst_in)
        (reg_wr_out || tx_push) |=> !(reg_wr_out || tx_push))
        else $error("one write strobe acted twice");

endmodule : hbi_host_port

// ### testbench/hbi_host_model.sv
// hbi_host_model: host cpu side of the strobe bus, driven through tasks.
// assumes one task at a time, entered at a falling edge of the clock.
module hbi_host_model (
    input wire logic core_clk_in,
    input wire logic [31:0] rd_bus_in,
    input wire logic oe_bus_in,
    output logic [31:0] wr_bus_out,
    output logic [7:0] addr_out,
    output logic read_strobe_n_out,
    output logic write_strobe_n_out,
    output logic chip_select_n_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        wr_bus_out = 32'h0000_0000;
        addr_out = 8'h00;
        read_strobe_n_out = 1'b1;
        write_strobe_n_out = 1'b1;
        chip_select_n_out = 1'b1;
    end

    // ==========================================================
    // word accesses; the address is a word index, bits 1..0 never leave
    // the host
    task automatic host_write(input logic [7:0] a, input logic [31:0] d,
                              input logic cs_n);
        addr_out = a;
        wr_bus_out = d;
        chip_select_n_out = cs_n;
        write_strobe_n_out = 1'b0;
        @(posedge core_clk_in);
        @(negedge core_clk_in);
        write_strobe_n_out = 1'b1;
        chip_select_n_out = 1'b1;
        // released bus shows the inverse, so a stale word cannot pass
        wr_bus_out = ~d;
        @(negedge core_clk_in);
    endtask : host_write

    task automatic host_read(input logic [7:0] a, input logic cs_n,
                             output logic [31:0] d, output logic oe);
        addr_out = a;
        chip_select_n_out = cs_n;
        read_strobe_n_out = 1'b0;
        repeat (2) @(posedge core_clk_in);
        #1;
        d = rd_bus_in;
        oe = oe_bus_in;
        @(negedge core_clk_in);
        read_strobe_n_out = 1'b1;
        chip_select_n_out = 1'b1;
        @(negedge core_clk_in);
    endtask : host_read
endmodule : hbi_host_model

// ### testbench/host_bus_pin_interface_bench.sv
// host_bus_pin_interface_bench: self-checking bench for hbi_host_port.
// assumes a register file that answers in the cycle of the read pulse.
module host_bus_pin_interface_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic dfs = 1'b0;
    logic be = 1'b0;
    logic tx_ready = 1'b0;
    logic [31:0] rx_data = 32'h0000_0000;
    logic rx_valid = 1'b0;
    logic [31:0] hd_in, hd_out, reg_wdata, reg_rdata, tx_data, wdat, d;
    logic [7:0] haddr, reg_addr, waddr;
    logic rd_n, wr_n, cs_n, oe, reg_wr, reg_rd, tx_valid, rx_ready, o;
    int err_total = 0;
    int tests_run = 0;
    int wr_cnt = 0;
    int rd_cnt = 0;

    always #5 core_clk = ~core_clk;
    assign reg_rdata = 32'hA1B2_C3D4 ^ {24'h00_0000, reg_addr};

    hbi_host_port dut (.core_clk_in(core_clk), .rst_in(rst),
        .host_data_in(hd_in), .host_data_out(hd_out),
        .host_data_oe_out(oe), .host_addr_in(haddr),
        .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n),
        .chip_select_n_in(cs_n), .direct_fifo_sel_in(dfs),
        .big_endian_sel_in(be), .reg_addr_out(reg_addr),
        .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr),
        .reg_rd_out(reg_rd), .reg_rdata_in(reg_rdata),
        .tx_data_out(tx_data), .tx_valid_out(tx_valid),
        .tx_ready_in(tx_ready), .rx_data_in(rx_data),
        .rx_valid_in(rx_valid), .rx_ready_out(rx_ready));

    hbi_host_model host (.core_clk_in(core_clk), .rd_bus_in(hd_out),
        .oe_bus_in(oe), .wr_bus_out(hd_in), .addr_out(haddr),
        .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n),
        .chip_select_n_out(cs_n));

    // the write pulse is combinational, so look mid-cycle, away from edges
    always @(negedge core_clk) begin
        #2;
        if (reg_wr === 1'b1) begin
            wr_cnt++;
            waddr = reg_addr;
            wdat = reg_wdata;
        end
        if (reg_rd === 1'b1) begin
            rd_cnt++;
        end
    end

    function automatic logic [31:0] bs(input logic [31:0] x);
        return {x[7:0], x[15:8], x[23:16], x[31:24]};
    endfunction : bs

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask : chk

    // ==========================================================
    // scenarios
    task automatic t_reg_write();
        for (int i = 0; i < 2; i++) begin
            be = i[0];
            host.host_write(8'h10 + i[7:0], 32'h1122_3344, 1'b0);
            chk({24'h00_0000, waddr}, 32'h0000_0010 + i);
            chk(wdat, i ? 32'h4433_2211 : 32'h1122_3344);
        end
        host.host_write(8'h20, 32'h5555_AAAA, 1'b1);
        chk(wr_cnt, 32'h0000_0002);
    endtask : t_reg_write

    task automatic t_reg_read();
        for (int i = 0; i < 2; i++) begin
            be = i[0];
            host.host_read(8'h40, 1'b0, d, o);
            chk({31'h0, o}, 32'h0000_0001);
            chk(d, i ? bs(32'hA1B2_C394) : 32'hA1B2_C394);
        end
        host.host_read(8'h40, 1'b1, d, o);
        chk({31'h0, o}, 32'h0000_0000);
        chk(rd_cnt, 32'h0000_0002);
    endtask : t_reg_read

    // 17 pushes into a 16-deep stalled fifo, then a full drain; the first
    // goes through the transmit port index, the rest in direct mode
    task automatic t_tx_fill();
        be = 1'b0;
        for (int i = 0; i < 17; i++) begin
            dfs = (i != 0);
            host.host_write(i[7:0] * 8'h07 + 8'h01, 32'h0101_0000 + i,
                            1'b0);
        end
        chk(wr_cnt, 32'h0000_0002);
        tx_ready = 1'b1;
        for (int i = 0; i < 16; i++) begin
            chk({31'h0, tx_valid}, 32'h0000_0001);
            chk(tx_data, 32'h0101_0000 + i);
            @(negedge core_clk);
        end
        chk({31'h0, tx_valid}, 32'h0000_0000);
        tx_ready = 1'b0;
    endtask : t_tx_fill

    task automatic t_rx_drain();
        dfs = 1'b1;
        be = 1'b1;
        rx_valid = 1'b1;
        for (int i = 0; i < 16; i++) begin
            rx_data = 32'h5A00_0000 + i;
            @(negedge core_clk);
        end
        rx_valid = 1'b0;
        chk({31'h0, rx_ready}, 32'h0000_0000);
        // the first pop goes through the receive port index, not direct mode
        for (int i = 0; i < 17; i++) begin
            dfs = (i != 0);
            host.host_read(i[7:0] * 8'h33, 1'b0, d, o);
            chk(d, i < 16 ? bs(32'h5A00_0000 + i) : 32'h0);
        end
        chk({31'h0, rx_ready}, 32'h0000_0001);
        chk(rd_cnt, 32'h0000_0002);
        dfs = 1'b0;
    endtask : t_rx_drain

    // a one-cycle reset in mid-run clears the read word and both fifos
    task automatic t_mid_reset();
        be = 1'b0;
        host.host_write(hbi_pkg::TX_DATA_IDX, 32'h0707_0707, 1'b0);
        host.host_read(8'h40, 1'b0, d, o);
        chk({31'h0, tx_valid}, 32'h0000_0001);
        rst = 1'b1;
        @(negedge core_clk);
        chk(hd_out, hbi_pkg::DATA_RST);
        chk({30'h0, tx_valid, rx_ready}, 32'h0000_0001);
        rst = 1'b0;
        @(negedge core_clk);
        host.host_read(8'h40, 1'b0, d, o);
        chk(d, 32'hA1B2_C394);
    endtask : t_mid_reset

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // ==========================================================
    // main sequence and watchdog; the tests need about 160 cycles
    initial begin
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        t_reg_write();
        t_reg_read();
        t_tx_fill();
        t_rx_drain();
        t_mid_reset();
        close_out();
    end

    initial begin
        #20000;
        err_total++;
        close_out();
    end
endmodule : host_bus_pin_interface_bench
